/* File: src/adcc_map.vh */
// register map, field positions and timing counts of the converter control
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// ---------------------------------------------------------------
// special function register addresses
// ---------------------------------------------------------------
`define ADCC_CTRL_ADDR 8'hD8
`define ADCC_RESULT_ADDR 8'hD9
`define ADCC_TRIG_ADDR 8'hDA
`define ADCC_CTRL_BIT_BASE 8'hD8

// ---------------------------------------------------------------
// converter_control fields
// ---------------------------------------------------------------
`define ADCC_PRESCALE_BIT 7
`define ADCC_LONG_SAMPLE_BIT 6
`define ADCC_RSVD5_BIT 5
`define ADCC_BUSY_BIT 4
`define ADCC_CONT_BIT 3
`define ADCC_ZERO2_BIT 2
`define ADCC_CH_HIGH_BIT 1
`define ADCC_CH_LOW_BIT 0
`define ADCC_CTRL_RESET 8'h00
`define ADCC_RESULT_RESET 8'h00
`define ADCC_TRIG_READ 8'h00

// ---------------------------------------------------------------
// timing in converter master clocks
// ---------------------------------------------------------------
`define ADCC_SAMPLE_SHORT 16
`define ADCC_SAMPLE_LONG 64
`define ADCC_APPROX_CLKS 64
`define ADCC_STEP_CLKS 8

`endif

/* File: src/adcc_sar.v */
// successive approximation register stepping one bit per eight master clocks
`default_nettype none

module adcc_sar #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  // control
  input wire tick_in,
  input wire start_in,
  input wire comp_in,
  // results
  output wire [WIDTH-1:0] trial_out,
  output wire [WIDTH-1:0] value_out,
  output wire done_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg run_reg; // approximation in progress
  reg [5:0] cnt_reg; // master clocks elapsed
  reg [WIDTH-1:0] code_reg; // bits decided so far
  reg [WIDTH-1:0] mask_reg; // bit under test, one-hot
  wire step_end; // last master clock of a bit step

  assign step_end = tick_in && (cnt_reg[2:0] == 3'h7);
  assign trial_out = code_reg | mask_reg;
  // final code includes the decision on the last bit
  assign value_out = comp_in ? trial_out : code_reg;
  // sixty-four master clocks after start
  assign done_out = run_reg && tick_in && (cnt_reg == 6'h3F);

  // ---------------------------------------------------------------
  // bit stepping
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_reg <= 1'b0;
      cnt_reg <= 6'h00;
      code_reg <= {WIDTH{1'b0}};
      mask_reg <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      if (start_in) begin
        // begin at the most significant bit
        run_reg <= 1'b1;
        cnt_reg <= 6'h00;
        code_reg <= {WIDTH{1'b0}};
        mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      end else if (run_reg && tick_in) begin
        cnt_reg <= cnt_reg + 6'h01;
        if (done_out) begin
          run_reg <= 1'b0;
        end
        if (step_end) begin
          // keep the trial bit when input is above it
          if (comp_in) begin
            code_reg <= code_reg | mask_reg;
          end
          mask_reg <= mask_reg >> 1;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: src/adcc_top.v */
// converter control: registers, timing and sequencing of the 8-bit converter
//
// Operation
// R1 - default: 16 sample, 64 approximation clocks
// R2 - long sample select: sample 64 clocks
// R3 - prescale enable halves master clock rate
// R4 - single mode: one conversion per trigger
// R5 - continuous mode: restart after each completion
// R6 - busy flag bit 4, high while converting
// R7 - busy flag ignores software writes
// R8 - channel select picks one of four inputs
// R9 - result held until next conversion
// R10 - no new conversion until result read
// R11 - result register readable and writable
// R12 - any trigger write starts; write zero
// R13 - trigger has no storage, address only
// R14 - software writes bit 2 zero
// R15 - control register bit set, clear, test
// R16 - software lets new channel settle
// R17 - result written and busy cleared together
`default_nettype none
`include "adcc_map.vh"

module adcc_top #(
  parameter WIDTH = 8
) (
  // clock, enable and reset
  input wire clk_in,
  input wire ce_in,
  input wire nrst_in,
  // special function register byte access
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  input wire [7:0] sfr_wdata_in,
  output reg [7:0] sfr_rdata_out,
  // bit access to converter_control
  input wire [7:0] bit_addr_in,
  input wire bit_wr_in,
  input wire bit_val_in,
  input wire bit_rd_in,
  output reg bit_rdata_out,
  // analog side
  input wire comp_in,
  output reg [1:0] channel_sel_out,
  output reg sample_out,
  output reg [WIDTH-1:0] trial_out,
  output reg busy_out
);

  // ---------------------------------------------------------------
  // state encoding
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001; // waiting for a start
  localparam [2:0] ST_SAMPLE = 3'b010; // input switch closed
  localparam [2:0] ST_CONV = 3'b100; // approximation running

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [2:0] state_reg; // sequencer state
  reg [2:0] state_next; // next sequencer state
  reg prescale_enable_reg; // master clock at half rate
  reg long_sample_select_reg; // sample phase 64 clocks
  reg continuous_mode_select_reg; // restart after completion
  reg channel_select_high_reg; // channel select bit 1
  reg channel_select_low_reg; // channel select bit 0
  reg conversion_busy_flag_reg; // conversion in progress
  reg [WIDTH-1:0] conversion_result_reg; // last result
  reg start_pend_reg; // start waiting for service
  reg result_read_reg; // result read since stored
  reg half_reg; // prescaler phase
  reg [6:0] long_sample_select_cnt_reg; // master clocks in sample phase

  // ---------------------------------------------------------------
  // decode and helpers
  // ---------------------------------------------------------------
  wire ctrl_wr; // byte write to converter_control
  wire result_wr; // byte write to conversion_result
  wire result_rd; // byte read of conversion_result
  wire trig_wr; // write to conversion_start_trigger
  wire bit_in_ctrl; // bit address falls in converter_control
  wire bit_hit_wr; // bit write inside converter_control
  wire tick; // one converter master clock
  wire [6:0] long_sample_select_len; // selected sample length
  wire start_go; // start a conversion this cycle
  wire long_sample_select_done; // sample phase complete
  wire sar_start; // launch approximation
  wire sar_done; // approximation complete
  wire [WIDTH-1:0] sar_trial; // code applied to the comparator
  wire [WIDTH-1:0] sar_value; // finished code
  wire [7:0] ctrl_view; // converter_control as read

  // byte image of converter_control
  function [7:0] ctrl_image;
    input prescale_enable;
    input long_sample_select;
    input busy;
    input cont;
    input [1:0] ch;
    begin
      ctrl_image = 8'h00;
      ctrl_image[`ADCC_PRESCALE_BIT] = prescale_enable;
      ctrl_image[`ADCC_LONG_SAMPLE_BIT] = long_sample_select;
      ctrl_image[`ADCC_BUSY_BIT] = busy;
      ctrl_image[`ADCC_CONT_BIT] = cont;
      ctrl_image[`ADCC_CH_HIGH_BIT] = ch[1];
      ctrl_image[`ADCC_CH_LOW_BIT] = ch[0];
    end
  endfunction

  assign ctrl_wr = sfr_wr_in && (sfr_addr_in == `ADCC_CTRL_ADDR);
  assign result_wr = sfr_wr_in && (sfr_addr_in == `ADCC_RESULT_ADDR);
  assign result_rd = sfr_rd_in && (sfr_addr_in == `ADCC_RESULT_ADDR);
  // only the address is decoded, data is not looked at
  assign trig_wr = sfr_wr_in && (sfr_addr_in == `ADCC_TRIG_ADDR); // [R12] [R13]
  // bit addresses of converter_control share its upper five bits
  assign bit_in_ctrl = ({bit_addr_in[7:3], 3'h0} == `ADCC_CTRL_BIT_BASE);
  assign bit_hit_wr = bit_wr_in && bit_in_ctrl; // [R15]

  assign ctrl_view = ctrl_image(prescale_enable_reg, long_sample_select_reg,
    conversion_busy_flag_reg, continuous_mode_select_reg,
    {channel_select_high_reg, channel_select_low_reg});

  // every internal clock, or every second one with prescaler on
  assign tick = !prescale_enable_reg || half_reg; // [R3]
  // sample length in master clocks
  assign long_sample_select_len = long_sample_select_reg ? 7'd`ADCC_SAMPLE_LONG :
    7'd`ADCC_SAMPLE_SHORT; // [R1] [R2]
  // start needs a pending request and a consumed result
  assign start_go = (state_reg == ST_IDLE) && start_pend_reg &&
    result_read_reg; // [R10]
  assign long_sample_select_done = (state_reg == ST_SAMPLE) && tick &&
    (long_sample_select_cnt_reg == long_sample_select_len - 7'd1);
  assign sar_start = long_sample_select_done;

  // ---------------------------------------------------------------
  // approximation engine
  // ---------------------------------------------------------------
  adcc_sar #(
    .WIDTH(WIDTH)
  ) u_sar (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .start_in(sar_start),
    .comp_in(comp_in),
    .trial_out(sar_trial),
    .value_out(sar_value),
    .done_out(sar_done)
  );

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_go) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (long_sample_select_done) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        // approximation takes 64 master clocks
        if (sar_done) begin
          state_next = ST_IDLE; // [R1]
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer, prescaler and sample counter
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      half_reg <= 1'b0;
      long_sample_select_cnt_reg <= 7'h00;
    end else if (ce_in) begin
      state_reg <= state_next;
      // prescaler phase restarts with each conversion
      if (start_go) begin
        half_reg <= 1'b0;
      end else begin
        half_reg <= ~half_reg;
      end
      // count master clocks of the sample phase
      if (start_go) begin
        long_sample_select_cnt_reg <= 7'h00;
      end else if (state_reg == ST_SAMPLE && tick) begin
        long_sample_select_cnt_reg <= long_sample_select_cnt_reg + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // start request and result handshake
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_pend_reg <= 1'b0;
      result_read_reg <= 1'b1;
    end else if (ce_in) begin
      // a trigger in the start cycle stays pending
      if (trig_wr) begin
        start_pend_reg <= 1'b1; // [R12]
      end else if (sar_done && continuous_mode_select_reg) begin
        start_pend_reg <= 1'b1; // [R5]
      end else if (start_go) begin
        start_pend_reg <= 1'b0; // [R4]
      end
      // a new result is unread even if read in the same cycle
      if (sar_done) begin
        result_read_reg <= 1'b0; // [R10]
      end else if (result_rd) begin
        result_read_reg <= 1'b1; // [R10]
      end
    end
  end

  // ---------------------------------------------------------------
  // converter_control and busy flag
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prescale_enable_reg <= 1'b0;
      long_sample_select_reg <= 1'b0;
      continuous_mode_select_reg <= 1'b0;
      channel_select_high_reg <= 1'b0;
      channel_select_low_reg <= 1'b0;
      conversion_busy_flag_reg <= 1'b0;
    end else if (ce_in) begin
      // byte write; busy, reserved and bit 2 are not stored
      if (ctrl_wr) begin
        prescale_enable_reg <= sfr_wdata_in[`ADCC_PRESCALE_BIT];
        long_sample_select_reg <= sfr_wdata_in[`ADCC_LONG_SAMPLE_BIT];
        continuous_mode_select_reg <= sfr_wdata_in[`ADCC_CONT_BIT];
        channel_select_high_reg <= sfr_wdata_in[`ADCC_CH_HIGH_BIT];
        channel_select_low_reg <= sfr_wdata_in[`ADCC_CH_LOW_BIT];
      end else if (bit_hit_wr) begin
        // single-bit set or clear
        case (bit_addr_in[2:0])
          3'h7: prescale_enable_reg <= bit_val_in; // [R15]
          3'h6: long_sample_select_reg <= bit_val_in; // [R15]
          3'h3: continuous_mode_select_reg <= bit_val_in; // [R15]
          3'h1: channel_select_high_reg <= bit_val_in; // [R15]
          3'h0: channel_select_low_reg <= bit_val_in; // [R15]
          default: begin
            // busy and fixed bits ignore the write
          end
        endcase
      end
      // busy follows the hardware only
      if (start_go) begin
        conversion_busy_flag_reg <= 1'b1; // [R6] [R7]
      end else if (sar_done) begin
        conversion_busy_flag_reg <= 1'b0; // [R6] [R17]
      end
    end
  end

  // ---------------------------------------------------------------
  // conversion_result
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      conversion_result_reg <= `ADCC_RESULT_RESET;
    end else if (ce_in) begin
      // completion stores the code in the busy clear cycle
      if (sar_done) begin
        conversion_result_reg <= sar_value; // [R9] [R17]
      end else if (result_wr) begin
        conversion_result_reg <= sfr_wdata_in[WIDTH-1:0]; // [R11]
      end
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sfr_rdata_out <= 8'h00;
      bit_rdata_out <= 1'b0;
    end else if (ce_in) begin
      if (sfr_rd_in) begin
        case (sfr_addr_in)
          `ADCC_CTRL_ADDR: sfr_rdata_out <= ctrl_view;
          `ADCC_RESULT_ADDR: sfr_rdata_out <= conversion_result_reg; // [R11]
          `ADCC_TRIG_ADDR: sfr_rdata_out <= `ADCC_TRIG_READ; // [R13]
          default: sfr_rdata_out <= 8'h00;
        endcase
      end
      // bit test of converter_control
      if (bit_rd_in) begin
        bit_rdata_out <= bit_in_ctrl && ctrl_view[bit_addr_in[2:0]]; // [R15]
      end
    end
  end

  // ---------------------------------------------------------------
  // analog side outputs
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      channel_sel_out <= 2'h0;
      sample_out <= 1'b0;
      trial_out <= {WIDTH{1'b0}};
      busy_out <= 1'b0;
    end else if (ce_in) begin
      // multiplexer follows the select bits one clock later, also during a conversion
      channel_sel_out <= {channel_select_high_reg,
        channel_select_low_reg}; // [R8]
      sample_out <= (state_next == ST_SAMPLE);
      trial_out <= sar_trial;
      busy_out <= conversion_busy_flag_reg;
    end
  end

endmodule

`default_nettype wire

/* File: verif/adcc_analog_model.sv */
// behavioural four-channel analog source with its comparator
`default_nettype none

module adcc_analog_model #(
  parameter logic [7:0] LVL0 = 8'h3C, // level on channel 0
  parameter logic [7:0] LVL1 = 8'hA5, // level on channel 1
  parameter logic [7:0] LVL2 = 8'h00, // level on channel 2
  parameter logic [7:0] LVL3 = 8'hFF // level on channel 3
) (
  // selection from the converter
  input wire logic [1:0] channel_sel_in,
  input wire logic [7:0] trial_in,
  // comparator decision
  output logic comp_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] level; // voltage of the routed channel

  // ---------------------------------------------------------------
  // input multiplexer and comparator
  // ---------------------------------------------------------------
  // channel bits pick one of four inputs
  always_comb begin
    case (channel_sel_in)
      2'h0: level = LVL0;
      2'h1: level = LVL1;
      2'h2: level = LVL2;
      default: level = LVL3;
    endcase
  end
  // at or above the trial code keeps the bit, so the result equals level
  assign comp_out = (level >= trial_in);
endmodule

`default_nettype wire

/* File: verif/adcc_top_monitor.sv */
// concurrent checks on the ports of the converter control
`default_nettype none

module adcc_top_monitor #(
  parameter WIDTH = 8
) (
  // clock, enable and reset
  input wire clk_in,
  input wire ce_in,
  input wire nrst_in,
  // byte access
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  input wire [7:0] sfr_wdata_in,
  input wire [7:0] sfr_rdata_out,
  // bit access
  input wire [7:0] bit_addr_in,
  input wire bit_wr_in,
  input wire bit_val_in,
  input wire bit_rd_in,
  input wire bit_rdata_out,
  // analog side
  input wire comp_in,
  input wire [1:0] channel_sel_out,
  input wire sample_out,
  input wire [WIDTH-1:0] trial_out,
  input wire busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  logic [8:0] busy_cnt_reg; // cycles busy has been high
  logic [8:0] long_sample_select_cnt_reg; // cycles sample has been high
  logic unread_reg; // a result came and was not read yet

  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_cnt_reg <= 9'h000;
      long_sample_select_cnt_reg <= 9'h000;
      unread_reg <= 1'b0;
    end else begin
      busy_cnt_reg <= busy_out ? busy_cnt_reg + 9'h001 : 9'h000;
      long_sample_select_cnt_reg <= sample_out ? long_sample_select_cnt_reg + 9'h001 : 9'h000;
      // a result read clears it; busy still seen high afterwards means
      // the read came no later than the store, so it counts as unread
      if (sfr_rd_in && ce_in && sfr_addr_in == 8'hD9) begin
        unread_reg <= 1'b0;
      end else if (busy_out) begin
        unread_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_busy_len: assert property (
    $fell(busy_out) |-> busy_cnt_reg inside {80, 128, 160, 256})
    else $error("busy length not a legal conversion time");
  chk_busy_bound: assert property (busy_cnt_reg <= 9'h100)
    else $error("busy longer than slowest conversion");
  chk_sample_len: assert property (
    $fell(sample_out) |-> long_sample_select_cnt_reg inside {16, 32, 64, 128})
    else $error("sample phase length wrong");
  chk_sample_busy: assert property (
    $rose(sample_out) |-> ##[0:3] busy_out)
    else $error("sampling without busy");
  chk_start_unread: assert property ($rose(busy_out) |-> !unread_reg)
    else $error("conversion started with result unread");
  chk_trig_read: assert property (
    sfr_rd_in && ce_in && sfr_addr_in == 8'hDA |=> sfr_rdata_out == 8'h00)
    else $error("trigger read not zero");
  chk_ctrl_fixed: assert property (
    sfr_rd_in && ce_in && sfr_addr_in == 8'hD8
    |=> sfr_rdata_out[5] == 1'b0 && sfr_rdata_out[2] == 1'b0)
    else $error("fixed control bits not zero");
  chk_ctrl_busy: assert property (
    sfr_rd_in && ce_in && sfr_addr_in == 8'hD8
    |=> sfr_rdata_out[4] == busy_out)
    else $error("control busy bit differs from busy");
  chk_bit_busy: assert property (
    bit_rd_in && ce_in && bit_addr_in == 8'hDC |=> bit_rdata_out == busy_out)
    else $error("bit test of busy differs from busy");
  chk_rdata_hold: assert property (
    !sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data moved without a read");
endmodule

bind adcc_top adcc_top_monitor #(.WIDTH(WIDTH)) adcc_top_monitor_inst (
  .clk_in, .ce_in, .nrst_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in,
  .sfr_wdata_in, .sfr_rdata_out, .bit_addr_in, .bit_wr_in, .bit_val_in,
  .bit_rd_in, .bit_rdata_out, .comp_in, .channel_sel_out, .sample_out,
  .trial_out, .busy_out);

`default_nettype wire

/* File: verif/adcc_top_tb_top.sv */
// self-checking bench of the converter control
`default_nettype none
`include "adcc_map.vh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  mismatches++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module adcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in = 1'b0; // system clock
  logic nrst_in = 1'b0; // reset, active low
  logic ce_in = 1'b1; // clock enable
  logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, bit_addr_in = 8'h00;
  logic sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
  logic bit_wr_in = 1'b0, bit_val_in = 1'b0, bit_rd_in = 1'b0;
  logic [7:0] sfr_rdata_out, trial_out;
  logic bit_rdata_out, comp_in, sample_out, busy_out;
  logic [1:0] channel_sel_out;
  int mismatches = 0, comparisons = 0;
  logic [7:0] d; // byte read back
  logic b; // bit read back
  logic [7:0] lvl [4] = '{8'h3C, 8'hA5, 8'h00, 8'hFF}; // channel levels
  int eb [4] = '{80, 128, 160, 256}; // busy cycles per timing setting
  int es [4] = '{16, 64, 32, 128}; // sample cycles per timing setting

  // ---------------------------------------------------------------
  // design and analog side
  // ---------------------------------------------------------------
  adcc_top #(.WIDTH(8)) adcc_top_inst (.clk_in, .ce_in, .nrst_in,
    .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
    .bit_addr_in, .bit_wr_in, .bit_val_in, .bit_rd_in, .bit_rdata_out,
    .comp_in, .channel_sel_out, .sample_out, .trial_out, .busy_out);
  adcc_analog_model adcc_analog_model_inst (.channel_sel_in(channel_sel_out),
    .trial_in(trial_out), .comp_out(comp_in));

  always #5 clk_in = ~clk_in;

  // ---------------------------------------------------------------
  // access tasks, all driven on the falling edge
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_wdata_in = v;
    sfr_wr_in = 1'b1;
    @(negedge clk_in);
    sfr_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(negedge clk_in);
    sfr_rd_in = 1'b0;
    v = sfr_rdata_out;
  endtask
  task automatic bwr(input logic [7:0] a, input logic v);
    @(negedge clk_in);
    bit_addr_in = a;
    bit_val_in = v;
    bit_wr_in = 1'b1;
    @(negedge clk_in);
    bit_wr_in = 1'b0;
  endtask
  task automatic brd(input logic [7:0] a, output logic v);
    @(negedge clk_in);
    bit_addr_in = a;
    bit_rd_in = 1'b1;
    @(negedge clk_in);
    bit_rd_in = 1'b0;
    v = bit_rdata_out;
  endtask

  // closing report
  task automatic test_done;
    $display("compared %0d, mismatched %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // bounded wait for busy to reach a level
  task automatic waitb(input logic v, input int n);
    int i;
    for (i = 0; i < n && busy_out !== v; i++) @(negedge clk_in);
    if (i == n) begin
      $display("[ERR] busy wait ran out, exp %h", v);
      mismatches++;
      test_done();
    end
  endtask
  // count busy and sample cycles of one conversion
  task automatic conv(input int xb, input int xs);
    int nb, ns, i;
    bit seen;
    nb = 0;
    ns = 0;
    seen = 1'b0;
    for (i = 0; i < 700; i++) begin
      @(negedge clk_in);
      if (busy_out === 1'b1) begin
        nb++;
        seen = 1'b1;
      end else if (seen) break;
      if (sample_out === 1'b1) ns++;
    end
    `CHK("busy cycles", xb, nb)
    `CHK("sample cycles", xs, ns)
    if (i == 700) begin
      $display("[ERR] conversion wait ran out, exp %0d", xb);
      mismatches++;
      test_done();
    end
  endtask
  // busy must stay low for n cycles
  task automatic idle(input int n);
    bit hit;
    hit = 1'b0;
    repeat (n) begin
      @(negedge clk_in);
      if (busy_out !== 1'b0) hit = 1'b1;
    end
    `CHK("stays idle", 1'b0, hit)
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk_in);
    nrst_in = 1'b1;
    rd(`ADCC_CTRL_ADDR, d);
    `CHK("control reset", 8'h00, d)
    rd(`ADCC_RESULT_ADDR, d);
    `CHK("result reset", 8'h00, d)
    $display("test reset done");
    // every timing setting, each on its own channel
    for (int k = 0; k < 4; k++) begin
      wr(`ADCC_CTRL_ADDR, 8'(k * 64 + k));
      repeat (20) @(negedge clk_in); // let the new input settle
      wr(`ADCC_TRIG_ADDR, 8'h00);
      conv(eb[k], es[k]);
      rd(`ADCC_RESULT_ADDR, d);
      `CHK("result", lvl[k], d)
    end
    idle(300);
    $display("test timing done");
    // trigger while unread waits for the read
    wr(`ADCC_CTRL_ADDR, 8'h01);
    repeat (20) @(negedge clk_in);
    wr(`ADCC_TRIG_ADDR, 8'h00);
    conv(80, 16);
    wr(`ADCC_TRIG_ADDR, 8'h00);
    idle(200);
    rd(`ADCC_RESULT_ADDR, d);
    `CHK("result held", lvl[1], d)
    waitb(1'b1, 20);
    bwr(8'hDC, 1'b0);
    brd(8'hDC, b);
    `CHK("busy bit kept", 1'b1, b)
    wr(`ADCC_CTRL_ADDR, 8'h11);
    waitb(1'b0, 300);
    rd(`ADCC_RESULT_ADDR, d);
    `CHK("second result", lvl[1], d)
    rd(`ADCC_CTRL_ADDR, d);
    `CHK("busy not written", 8'h01, d)
    wr(`ADCC_CTRL_ADDR, 8'h33);
    rd(`ADCC_CTRL_ADDR, d);
    `CHK("fixed bits", 8'h03, d)
    $display("test pending done");
    // register access kinds
    wr(`ADCC_RESULT_ADDR, 8'h5A);
    rd(`ADCC_RESULT_ADDR, d);
    `CHK("result write", 8'h5A, d)
    // a write while the enable is low must not land
    ce_in = 1'b0;
    wr(`ADCC_RESULT_ADDR, 8'hC3);
    ce_in = 1'b1;
    rd(`ADCC_RESULT_ADDR, d);
    `CHK("frozen write", 8'h5A, d)
    rd(`ADCC_TRIG_ADDR, d);
    `CHK("trigger read", 8'h00, d)
    rd(8'h55, d);
    `CHK("unmapped read", 8'h00, d)
    wr(`ADCC_CTRL_ADDR, 8'h00);
    bwr(8'hD9, 1'b1);
    brd(8'hD9, b);
    `CHK("bit set", 1'b1, b)
    rd(`ADCC_CTRL_ADDR, d);
    `CHK("bit set byte", 8'h02, d)
    $display("test access done");
    // continuous mode on channel 2
    wr(`ADCC_CTRL_ADDR, 8'h0A);
    repeat (20) @(negedge clk_in);
    wr(`ADCC_TRIG_ADDR, 8'h00);
    conv(80, 16);
    rd(`ADCC_RESULT_ADDR, d);
    `CHK("cont result", lvl[2], d)
    waitb(1'b1, 20);
    bwr(8'hDB, 1'b0);
    wr(`ADCC_RESULT_ADDR, 8'h5A);
    waitb(1'b0, 300);
    rd(`ADCC_RESULT_ADDR, d);
    `CHK("cont second", lvl[2], d)
    idle(300);
    $display("test continuous done");
    test_done();
  end
endmodule

`default_nettype wire
